// ---- hdl/drs_defs.svh ----
// Purpose: constants for the directional residual stage block
// Assumes: pclk at 125 MHz, one aligned 32-bit word per register
// Notes:   types live in drs_pkg
//
// Summary of operation
// - blocking input sampled once per program tick, used for that whole tick
// - pick-up with blocking off asserts start and begins operate timing
// - pick-up with blocking on gives blocked, no start or trip processing
// - blocking during start clears start and runs release timing as on pick-up loss
// - second-harmonic inrush blocking enable, disabled after reset
// - inrush limit is harmonic/fundamental ratio in 0.01 percent steps
// - operate timing selectable fixed_time_delay or inverse_time_delay
// - on and off events for start, trip, block, active and reactive start/trip
// - per event setting stores its on edge, off edge or both with stamp
// - cumulative counters for start, trip and blocked occurrences
// - four independent stages, each with its own event stream identity
// - each stage keeps its twelve newest fault records, oldest overwritten
// - record written on start, trip or blocked on edge with listed data
// - direction reported as undefined, forward or reverse
// - time left to trip shown while timing, 5 ms resolution
// - inverse expected operate time recomputed whenever current changes
// - measured current to pick-up setting ratio in 0.001 steps
// - reactive component reported alongside active component
// - condition reported as normal, started, tripped or blocked
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH
`define DRS_CLK_MHZ   125
`define DRS_MS_CYC    (`DRS_CLK_MHZ * 1000)
`define DRS_TICK_MS   5
`define DRS_BLK_LEAD_MS 5
`define DRS_PRE1_MS   20
`define DRS_PRE2_MS   200
`define DRS_HIST_N    (`DRS_PRE2_MS / `DRS_TICK_MS)
`define DRS_PRE1_N    (`DRS_PRE1_MS / `DRS_TICK_MS)
`define DRS_NSTG      4
`define DRS_NLOG      12
`define DRS_NEV       7
`define DRS_RATIO_K   1000
`define DRS_A_LOGSEL  8'h00
`define DRS_A_LOGDAT  8'h04
`define DRS_A_TIME    8'h08
`define DRS_STG_BIT   7
`define DRS_R_CFG     3'h0
`define DRS_R_DLY     3'h1
`define DRS_R_LIM     3'h2
`define DRS_R_STAT    3'h3
`define DRS_R_LIVE    3'h4
`define DRS_R_COMP    3'h5
`define DRS_R_CNT     3'h6
`define DRS_R_LOGN    3'h7
`define DRS_CFG_RST   32'h0000_fffc
`define DRS_DLY_RST   32'h0001_0014
`define DRS_LIM_RST   32'h03e8_0001
`define DRS_F_INV     0
`define DRS_F_INR     1
`define DRS_F_SEL     2
`define DRS_F_GRP     16
`define DRS_F_GND     19
`endif

// ---- hdl/drs_pkg.sv ----
// Purpose: shared types of the directional residual stage block
// Assumes: constants in drs_defs.svh
// Notes:   record is six bus words, word 0 lowest
package drs_pkg;
  typedef enum logic [2:0] {ST_NORM, ST_START, ST_REL, ST_TRIP, ST_TREL, ST_BLKD} drs_state_t;
  typedef enum logic [1:0] {COND_NORMAL, COND_STARTED, COND_TRIPPED, COND_BLOCKED} drs_cond_t;
  typedef enum logic [1:0] {DIR_UNDEF, DIR_FWD, DIR_REV, DIR_RSVD} drs_dir_t;
  typedef struct packed {
    logic        pick;
    logic        act_pick;
    logic        rea_pick;
    logic        blk;
    drs_dir_t    dir;
    logic [15:0] imag;
    logic [15:0] iact;
    logic [15:0] irea;
    logic [15:0] harm;
    logic [15:0] u0;
    logic [15:0] ang;
  } drs_meas_t;
  typedef struct packed {
    logic [15:0] rem;
    logic [15:0] ang;
    logic [15:0] rea;
    logic [15:0] act;
    logic [15:0] u0;
    logic [15:0] flt;
    logic [15:0] pre200;
    logic [15:0] pre20;
    logic [31:0] stamp;
    logic [24:0] rsvd;
    logic [1:0]  gnd;
    logic [2:0]  grp;
    logic [1:0]  ev;
  } drs_rec_t;
endpackage : drs_pkg

// ---- hdl/drs_stage.sv ----
// Purpose: start, trip and blocked sequencing of one stage
// Assumes: tick is a one-cycle program cycle pulse
// Notes:   all decisions happen on tick only
`timescale 1ns/1ps
module drs_stage (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        pick,
  input  wire logic        blk_in,
  input  wire logic        inrush_en,
  input  wire logic [15:0] harm,
  input  wire logic [15:0] harm_lim,
  input  wire logic [15:0] op_ticks,
  input  wire logic [15:0] rel_ticks,
  output logic             start,
  output logic             trip,
  output logic             blocked,
  output logic [15:0]      elapsed
);
  drs_pkg::drs_state_t st_ff, nxt_st;
  logic [15:0]         el_ff, nxt_el, rl_ff, nxt_rl;
  logic                blk;

  // blocking is only looked at on tick, so it holds for the cycle
  assign blk = blk_in | (inrush_en & (harm >= harm_lim));

  // ==========================================================
  // sequencing
  always_comb begin
    nxt_st = st_ff;
    nxt_el = el_ff;
    nxt_rl = rl_ff;
    if (tick) begin
      case (st_ff)
        drs_pkg::ST_NORM: if (pick) begin
          nxt_el = 16'h0;
          nxt_st = blk ? drs_pkg::ST_BLKD : drs_pkg::ST_START;
        end
        drs_pkg::ST_BLKD: if (!pick || !blk) nxt_st = drs_pkg::ST_NORM;
        drs_pkg::ST_START: begin
          nxt_el = el_ff + 16'h1;
          if (!pick || blk) begin
            nxt_st = drs_pkg::ST_REL;
            nxt_rl = 16'h0;
          end else if (el_ff + 16'h1 >= op_ticks) nxt_st = drs_pkg::ST_TRIP;
        end
        drs_pkg::ST_REL: begin
          nxt_rl = rl_ff + 16'h1;
          if (pick && !blk) nxt_st = drs_pkg::ST_START;
          else if (rl_ff + 16'h1 >= rel_ticks) nxt_st = drs_pkg::ST_NORM;
        end
        drs_pkg::ST_TRIP: if (!pick || blk) begin
          nxt_st = drs_pkg::ST_TREL;
          nxt_rl = 16'h0;
        end
        drs_pkg::ST_TREL: begin
          nxt_rl = rl_ff + 16'h1;
          if (pick && !blk) nxt_st = drs_pkg::ST_TRIP;
          else if (rl_ff + 16'h1 >= rel_ticks) nxt_st = drs_pkg::ST_NORM;
        end
        default: nxt_st = drs_pkg::ST_NORM;
      endcase
    end
  end

  // state and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= drs_pkg::ST_NORM;
      el_ff <= 16'h0;
      rl_ff <= 16'h0;
    end else begin
      st_ff <= nxt_st;
      el_ff <= nxt_el;
      rl_ff <= nxt_rl;
    end
  end

  // registered decode so the top sees clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start   <= 1'b0;
      trip    <= 1'b0;
      blocked <= 1'b0;
    end else begin
      start   <= nxt_st == drs_pkg::ST_START;
      trip    <= nxt_st == drs_pkg::ST_TRIP || nxt_st == drs_pkg::ST_TREL;
      blocked <= nxt_st == drs_pkg::ST_BLKD;
    end
  end
  assign elapsed = el_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pick_clear;
    tick && st_ff == drs_pkg::ST_NORM && pick && !blk;
  endsequence
  a_start_on_pick: assert property (s_pick_clear |=> start && !blocked)
    else $error("start missing after pick-up");
  a_block_on_pick: assert property (tick && st_ff == drs_pkg::ST_NORM && pick && blk |=> blocked && !start)
    else $error("blocked missing");
  a_block_drops_start: assert property (tick && start && blk |=> !start && !trip)
    else $error("start survived blocking");
  a_trip_from_start: assert property ($rose(trip) |-> $past(st_ff) == drs_pkg::ST_START && $past(tick))
    else $error("trip without start");
  a_tick_only: assert property (!tick |=> $stable(st_ff))
    else $error("state moved between ticks");
endmodule : drs_stage

// ---- hdl/drs_top.sv ----
// Purpose: four directional residual stages with events, counters and fault log
// Assumes: measurement inputs are on pclk; APB slave, zero wait after setup
// Notes:   event stream emits one event per clock from pending flags
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "drs_defs.svh"
module drs_top #(
  parameter int MS_CYC = `DRS_MS_CYC
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire drs_pkg::drs_meas_t [`DRS_NSTG-1:0] meas,
  output logic [`DRS_NSTG-1:0]                   stage_start,
  output logic [`DRS_NSTG-1:0]                   stage_trip,
  output logic [`DRS_NSTG-1:0]                   stage_blocked,
  output logic                                   ev_valid,
  output logic [1:0]                             ev_stage,
  output logic [3:0]                             ev_code,
  output logic [31:0]                            ev_stamp
);
  localparam int NS = `DRS_NSTG;
  localparam int NL = `DRS_NLOG;
  localparam int NH = `DRS_HIST_N;

  // ==========================================================
  // functions
  // inverse time shrinks the delay as current rises above pick-up
  function automatic logic [15:0] inv_time(input logic [15:0] op, input logic [15:0] pk, input logic [15:0] im);
    logic [31:0] q;
    q = (im == 16'h0) ? {16'h0, op} : ({16'h0, op} * {16'h0, pk}) / {16'h0, im};
    if (q > 32'h0000_ffff) q = 32'h0000_ffff;
    if (q == 32'h0) q = 32'h1;
    return q[15:0];
  endfunction : inv_time

  function automatic logic [15:0] ratio(input logic [15:0] im, input logic [15:0] pk);
    logic [31:0] q;
    q = (pk == 16'h0) ? 32'h0 : ({16'h0, im} * 32'(`DRS_RATIO_K)) / {16'h0, pk};
    if (q > 32'h0000_ffff) q = 32'h0000_ffff;
    return q[15:0];
  endfunction : ratio

  function automatic logic [5:0] hist_back(input logic [5:0] p, input int k);
    return 6'((32'(p) + NH - k) % NH);
  endfunction : hist_back

  // ==========================================================
  // time base: millisecond stamp and 5 ms program tick
  logic [31:0] ms_cnt_ff, msec_ff;
  logic [2:0]  tk_ff;
  logic        tick_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff <= 32'h0;
      msec_ff   <= 32'h0;
      tk_ff     <= 3'h0;
      tick_ff   <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (ms_cnt_ff == 32'(MS_CYC - 1)) begin
        ms_cnt_ff <= 32'h0;
        msec_ff   <= msec_ff + 32'h1;
        if (tk_ff == 3'(`DRS_TICK_MS - 1)) begin
          tk_ff   <= 3'h0;
          tick_ff <= 1'b1;
        end else tk_ff <= tk_ff + 3'h1;
      end else ms_cnt_ff <= ms_cnt_ff + 32'h1;
    end
  end

  // ==========================================================
  // settings
  logic [31:0] cfg_ff [NS];
  logic [31:0] dly_ff [NS];
  logic [31:0] lim_ff [NS];
  logic [8:0]  lsel_ff;
  logic        acc, wr_en;
  logic [1:0]  a_stg;
  logic [2:0]  a_reg;
  logic        a_is_stg;
  assign acc      = psel & penable & pready;
  assign wr_en    = acc & pwrite;
  assign a_is_stg = paddr[`DRS_STG_BIT];
  assign a_stg    = paddr[6:5];
  assign a_reg    = paddr[4:2];

  // writes land only in the completing access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NS; s++) begin
        cfg_ff[s] <= `DRS_CFG_RST;
        dly_ff[s] <= `DRS_DLY_RST;
        lim_ff[s] <= `DRS_LIM_RST;
      end
      lsel_ff <= 9'h0;
    end else if (wr_en) begin
      if (a_is_stg && a_reg == `DRS_R_CFG) cfg_ff[a_stg] <= pwdata;
      if (a_is_stg && a_reg == `DRS_R_DLY) dly_ff[a_stg] <= pwdata;
      if (a_is_stg && a_reg == `DRS_R_LIM) lim_ff[a_stg] <= pwdata;
      if (!a_is_stg && paddr == `DRS_A_LOGSEL) lsel_ff <= pwdata[8:0];
    end
  end

  // ==========================================================
  // stages
  logic [15:0] exp_ff [NS];
  logic [15:0] el    [NS];
  logic [15:0] ratio_ff [NS];
  logic [15:0] rem_ff [NS];
  for (genvar g = 0; g < NS; g++) begin : g_stg
    drs_stage u_stage (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (tick_ff),
      .pick      (meas[g].pick),
      .blk_in    (meas[g].blk),
      .inrush_en (cfg_ff[g][`DRS_F_INR]),
      .harm      (meas[g].harm),
      .harm_lim  (lim_ff[g][15:0]),
      .op_ticks  (exp_ff[g]),
      .rel_ticks (dly_ff[g][31:16]),
      .start     (stage_start[g]),
      .trip      (stage_trip[g]),
      .blocked   (stage_blocked[g]),
      .elapsed   (el[g])
    );
  end

  // live values follow the current every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NS; s++) begin
        exp_ff[s]   <= 16'h0;
        ratio_ff[s] <= 16'h0;
        rem_ff[s]   <= 16'h0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        exp_ff[s] <= cfg_ff[s][`DRS_F_INV] ? inv_time(dly_ff[s][15:0], lim_ff[s][31:16], meas[s].imag)
                                           : dly_ff[s][15:0];
        ratio_ff[s] <= ratio(meas[s].imag, lim_ff[s][31:16]);
        rem_ff[s]   <= (stage_start[s] && exp_ff[s] > el[s]) ? exp_ff[s] - el[s] : 16'h0;
      end
    end
  end

  // ==========================================================
  // event edges, pending flags and the outgoing stream
  logic [`DRS_NEV-1:0] sig [NS];
  logic [`DRS_NEV-1:0] prev_ff [NS];
  logic [`DRS_NEV-1:0] rise [NS];
  logic [`DRS_NEV-1:0] fall [NS];
  logic [63:0]         pend_ff, pend_set, pend_clr;
  logic [5:0]          pick_ix;
  logic                pick_any;
  always_comb begin
    pend_set = 64'h0;
    for (int s = 0; s < NS; s++) begin
      sig[s] = {stage_trip[s] & meas[s].rea_pick, stage_trip[s] & meas[s].act_pick,
                stage_start[s] & meas[s].rea_pick, stage_start[s] & meas[s].act_pick,
                stage_blocked[s], stage_trip[s], stage_start[s]};
      rise[s] = sig[s] & ~prev_ff[s];
      fall[s] = ~sig[s] & prev_ff[s];
      for (int e = 0; e < `DRS_NEV; e++) begin
        pend_set[s*16 + 2*e]     = rise[s][e] & cfg_ff[s][`DRS_F_SEL + 2*e];
        pend_set[s*16 + 2*e + 1] = fall[s][e] & cfg_ff[s][`DRS_F_SEL + 2*e + 1];
      end
    end
  end

  // lowest pending flag goes first
  always_comb begin
    pick_ix  = 6'h0;
    pick_any = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (pend_ff[i]) begin
        pick_ix  = 6'(i);
        pick_any = 1'b1;
      end
    end
    pend_clr = 64'h0;
    pend_clr[pick_ix] = pick_any;
  end

  // a new edge beats the clear of the same flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 64'h0;
      for (int s = 0; s < NS; s++) prev_ff[s] <= '0;
    end else begin
      pend_ff <= (pend_ff & ~pend_clr) | pend_set;
      for (int s = 0; s < NS; s++) prev_ff[s] <= sig[s];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_valid <= 1'b0;
      ev_stage <= 2'h0;
      ev_code  <= 4'h0;
      ev_stamp <= 32'h0;
    end else begin
      ev_valid <= pick_any;
      ev_stage <= pick_ix[5:4];
      ev_code  <= pick_ix[3:0];
      ev_stamp <= msec_ff;
    end
  end

  // ==========================================================
  // counters
  logic [9:0] cnt_ff [NS][3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NS; s++)
        for (int k = 0; k < 3; k++) cnt_ff[s][k] <= 10'h0;
    end else begin
      for (int s = 0; s < NS; s++)
        for (int k = 0; k < 3; k++)
          if (rise[s][k]) cnt_ff[s][k] <= cnt_ff[s][k] + 10'h1;
    end
  end

  // ==========================================================
  // pre-fault current history, one sample per tick
  logic [15:0] hist [NS][NH];
  logic [5:0]  hptr_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hptr_ff <= 6'h0;
    else if (tick_ff) hptr_ff <= (hptr_ff == 6'(NH - 1)) ? 6'h0 : hptr_ff + 6'h1;
  end
  always_ff @(posedge pclk) begin
    if (tick_ff)
      for (int s = 0; s < NS; s++) hist[s][hptr_ff] <= meas[s].imag;
  end

  // ==========================================================
  // fault log, twelve records a stage, ring overwrite
  drs_pkg::drs_rec_t log_mem [NS][NL];
  drs_pkg::drs_rec_t nrec [NS];
  logic [3:0]        wptr_ff [NS];
  logic [3:0]        lcnt_ff [NS];
  logic [NS-1:0]     lwr;
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      lwr[s]         = |rise[s][2:0];
      nrec[s]        = '0;
      nrec[s].ev     = rise[s][0] ? 2'h0 : (rise[s][1] ? 2'h1 : 2'h2);
      nrec[s].grp    = cfg_ff[s][`DRS_F_GRP +: 3];
      nrec[s].gnd    = cfg_ff[s][`DRS_F_GND +: 2];
      nrec[s].stamp  = msec_ff;
      nrec[s].pre20  = hist[s][hist_back(hptr_ff, `DRS_PRE1_N)];
      nrec[s].pre200 = hist[s][hist_back(hptr_ff, NH)];
      nrec[s].flt    = meas[s].imag;
      nrec[s].u0     = meas[s].u0;
      nrec[s].act    = meas[s].iact;
      nrec[s].rea    = meas[s].irea;
      nrec[s].ang    = meas[s].ang;
      nrec[s].rem    = rem_ff[s];
    end
  end
  always_ff @(posedge pclk) begin
    for (int s = 0; s < NS; s++)
      if (lwr[s]) log_mem[s][wptr_ff[s]] <= nrec[s];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NS; s++) begin
        wptr_ff[s] <= 4'h0;
        lcnt_ff[s] <= 4'h0;
      end
    end else begin
      for (int s = 0; s < NS; s++)
        if (lwr[s]) begin
          wptr_ff[s] <= (wptr_ff[s] == 4'(NL - 1)) ? 4'h0 : wptr_ff[s] + 4'h1;
          if (lcnt_ff[s] != 4'(NL)) lcnt_ff[s] <= lcnt_ff[s] + 4'h1;
        end
    end
  end

  // ==========================================================
  // read path
  logic [1:0]        rs;
  logic [3:0]        slot;
  drs_pkg::drs_rec_t rrec;
  logic [191:0]      rbits;
  logic [31:0]       logw, rdat;
  logic              rerr;
  drs_pkg::drs_cond_t cnd [NS];
  always_comb begin
    rs    = lsel_ff[1:0];
    slot  = 4'((32'(wptr_ff[rs]) + NL - 1 - 32'(lsel_ff[5:2])) % NL); // index 0 is newest
    rrec  = log_mem[rs][slot];
    rbits = rrec;
    logw  = (lsel_ff[5:2] < lcnt_ff[rs] && lsel_ff[8:6] < 3'h6) ? rbits[32*lsel_ff[8:6] +: 32] : 32'h0;
    for (int s = 0; s < NS; s++)
      cnd[s] = stage_blocked[s] ? drs_pkg::COND_BLOCKED :
               stage_trip[s]    ? drs_pkg::COND_TRIPPED :
               stage_start[s]   ? drs_pkg::COND_STARTED : drs_pkg::COND_NORMAL;
  end

  always_comb begin
    rdat = 32'h0;
    rerr = 1'b0;
    if (a_is_stg) begin
      case (a_reg)
        `DRS_R_CFG:  rdat = cfg_ff[a_stg];
        `DRS_R_DLY:  rdat = dly_ff[a_stg];
        `DRS_R_LIM:  rdat = lim_ff[a_stg];
        `DRS_R_STAT: rdat = {rem_ff[a_stg], 12'h0, meas[a_stg].dir, cnd[a_stg]};
        `DRS_R_LIVE: rdat = {exp_ff[a_stg], ratio_ff[a_stg]};
        `DRS_R_COMP: rdat = {meas[a_stg].irea, meas[a_stg].iact};
        `DRS_R_CNT:  rdat = {2'h0, cnt_ff[a_stg][2], cnt_ff[a_stg][1], cnt_ff[a_stg][0]};
        `DRS_R_LOGN: rdat = {28'h0, lcnt_ff[a_stg]};
        default:     rerr = 1'b1;
      endcase
    end else begin
      case (paddr)
        `DRS_A_LOGSEL: rdat = {23'h0, lsel_ff};
        `DRS_A_LOGDAT: rdat = logw;
        `DRS_A_TIME:   rdat = msec_ff;
        default:       rerr = 1'b1;
      endcase
    end
    if (paddr[1:0] != 2'h0) rerr = 1'b1;
  end

  // answer is ready in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rerr;
      if (psel & ~penable & ~pwrite) prdata <= rdat;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cnt_start: assert property (rise[0][0] |=> cnt_ff[0][0] == $past(cnt_ff[0][0]) + 10'h1)
    else $error("start counter missed an edge");
  a_log_depth: assert property (lcnt_ff[1] <= 4'(NL) && wptr_ff[1] < 4'(NL))
    else $error("log pointer out of range");
  a_log_wrap: assert property (lwr[2] && wptr_ff[2] == 4'(NL - 1) |=> wptr_ff[2] == 4'h0)
    else $error("log ring did not wrap");
  a_ev_gated: assert property (ev_valid && ev_code < 4'he |-> cfg_ff[ev_stage][`DRS_F_SEL + 32'(ev_code)])
    else $error("event emitted while unselected");
  a_ev_issued: assert property (pend_set[0] |=> ##[0:64] (ev_valid && ev_stage == 2'h0 && ev_code == 4'h0))
    else $error("pending event never issued");
  a_rem_idle: assert property (!stage_start[0] |=> rem_ff[0] == 16'h0)
    else $error("time left shown without timing");
  a_cond_map: assert property (stage_trip[0] |-> cnd[0] == drs_pkg::COND_TRIPPED || stage_blocked[0])
    else $error("condition mismatch");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
endmodule : drs_top

// ---- tb/drs_partner.sv ----
// Purpose: event buffer model that counts delivered events
// Assumes: event fields are valid while ev_valid is high
// Notes:   keeps only the counts that the bench compares
`timescale 1ns/1ps
module drs_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ev_valid,
  input  wire logic [1:0]  ev_stage,
  input  wire logic [3:0]  ev_code,
  input  wire logic [31:0] ev_stamp,
  output logic [7:0]       start_on_n,
  output logic [7:0]       blk_on_n,
  output logic [7:0]       stamp_bad_n
);
  logic [31:0] last_ff;
  // ==========
  // event capture
  // a real buffer stores every event; counting a few kinds is enough here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_on_n  <= 8'h00;
      blk_on_n    <= 8'h00;
      stamp_bad_n <= 8'h00;
      last_ff     <= 32'h0;
    end else if (ev_valid) begin
      last_ff <= ev_stamp;
      // start on is only expected from stage 0, block on from stages 1 and 2
      if (ev_code == 4'h0 && ev_stage == 2'h0) start_on_n <= start_on_n + 8'h01;
      if (ev_code == 4'h4 && (ev_stage == 2'h1 || ev_stage == 2'h2)) blk_on_n <= blk_on_n + 8'h01;
      // stamps never run back and are never zero once time has moved on
      if ((ev_stamp >= last_ff && ev_stamp != 32'h0) !== 1'b1) stamp_bad_n <= stamp_bad_n + 8'h01;
    end
  end
endmodule : drs_partner

// ---- tb/drs_top_bench.sv ----
// Purpose: apb driven checks of the four stage protection block
// Assumes: tick shortened by MS_CYC of 4, so one tick is 20 clocks
// Notes:   stages 0 to 2 run start, trip and block; stage 3 checks inverse-time live values
`timescale 1ns/1ps
module drs_top_bench;
  // ==========
  // signals
  logic                     pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, ev_valid;
  logic [7:0]               paddr = 8'h00, start_on_n, blk_on_n, stamp_bad_n;
  logic [31:0]              pwdata = 32'h0, prdata, q, ev_stamp;
  logic [3:0]               stage_start, stage_trip, stage_blocked, ev_code;
  logic [1:0]               ev_stage;
  drs_pkg::drs_meas_t [3:0] meas = '0;
  int                       failures = 0, check_count = 0, cyc = 0;

  drs_top #(.MS_CYC(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .meas, .stage_start, .stage_trip, .stage_blocked, .ev_valid, .ev_stage, .ev_code, .ev_stamp);
  drs_partner i_buf (.pclk, .presetn, .ev_valid, .ev_stage, .ev_code, .ev_stamp, .start_on_n, .blk_on_n,
    .stamp_bad_n);

  always #4 pclk = ~pclk;

  // ==========
  // tasks
  // one apb transfer; the idle edge first keeps back-to-back calls legal
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // k selects start, trip or blocked of stage s; bounded wait, then compare
  task automatic wait_out(input int k, input int s, input logic v);
    logic [2:0] f;
    for (int n = 0; n < 200; n++) begin
      f = {stage_blocked[s], stage_trip[s], stage_start[s]};
      if (f[k] === v) break;
      @(posedge pclk);
    end
    chk({31'h0, f[k]}, {31'h0, v});
  endtask : wait_out

  task automatic final_report;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ==========
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  // ==========
  // sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h80, 0); chk(q, 32'h0000_fffc);
    apb(0, 8'h84, 0); chk(q, 32'h0001_0014);
    apb(0, 8'h88, 0); chk(q, 32'h03e8_0001);
    apb(0, 8'h40, 0); chk({31'h0, e}, 32'h1);
    apb(1, 8'h84, 32'h0001_0003);
    meas[0].imag <= 16'h0200;
    meas[0].iact <= 16'h0012;
    meas[0].irea <= 16'h0034;
    meas[0].dir <= drs_pkg::DIR_FWD;
    meas[0].pick <= 1'b1;
    wait_out(0, 0, 1'b1);
    apb(0, 8'h8c, 0); chk(q, 32'h0003_0005);
    apb(0, 8'h90, 0); chk(q, 32'h0003_0200);
    apb(0, 8'h94, 0); chk(q, 32'h0034_0012);
    wait_out(1, 0, 1'b1);
    meas[0].pick <= 1'b0;
    wait_out(1, 0, 1'b0);
    meas[0].pick <= 1'b1;
    wait_out(0, 0, 1'b1);
    // block lands ten ms or more ahead of the three tick delay
    meas[0].blk <= 1'b1;
    wait_out(0, 0, 1'b0);
    chk({31'h0, stage_trip[0]}, 32'h0);
    meas[0].pick <= 1'b0;
    meas[0].blk <= 1'b0;
    meas[1].blk <= 1'b1;
    @(posedge pclk);
    meas[1].pick <= 1'b1;
    wait_out(2, 1, 1'b1);
    chk({31'h0, stage_start[1]}, 32'h0);
    apb(1, 8'hc0, 32'h0000_fffe);
    meas[2].harm <= 16'h0010;
    meas[2].pick <= 1'b1;
    wait_out(2, 2, 1'b1);
    meas <= '0;
    // three ticks cover release timing and the event drain
    repeat (60) @(posedge pclk);
    apb(0, 8'h98, 0); chk(q, 32'h0000_0402);
    apb(0, 8'hb8, 0); chk(q, 32'h0010_0000);
    apb(0, 8'h9c, 0); chk(q, 32'h3);
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h04, 0); chk(q, 32'h2);
    // stage 3: inverse time shrinks the expected delay as the current rises
    apb(1, 8'he0, 32'h0000_fffd);
    meas[3].imag <= 16'h07d0;
    apb(0, 8'hf0, 0); chk(q, 32'h000a_07d0);
    meas[3].imag <= 16'h0fa0;
    apb(0, 8'hf0, 0); chk(q, 32'h0005_0fa0);
    chk({24'h0, stamp_bad_n}, 32'h0);
    chk({24'h0, start_on_n}, 32'h2);
    chk({24'h0, blk_on_n}, 32'h2);
    final_report();
  end
endmodule : drs_top_bench
